// ### pkg/lec_map.svh
/*
  Offsets, field positions, reset values and counts of the LVDS output and event count block.
  Assumes inclusion by bare name from the package and the design files.
*/
// Operation
// - Bits 2..0 enable lane 2..0 drivers.
// - Lane enables act only under override bit 6.
// - Rate bit 5 selects DDR or half clock.
// - Invert bit 4 flips forwarded clock polarity.
// - Delay field 3:2 adds 100 ps per step.
// - Select bit 3 picks counter for reading.
// - Writing bit 2 clears recovery counter.
// - Writing bit 1 clears data counter.
// - Accumulate bit 4 keeps errors across runs.
// - Bit 3 masks code errors from count, lock.
`ifndef LEC_MAP_SVH
`define LEC_MAP_SVH
`define LEC_OFS_LANE 8'h27
`define LEC_OFS_CLK 8'h28
`define LEC_OFS_EVT 8'h2b
`define LEC_OFS_ERR 8'h2d
`define LEC_OFS_EVCNT 8'h3d
`define LEC_OFS_ERRLO 8'h3e
`define LEC_OFS_ERRHI 8'h3f
`define LEC_BIT_OVR 6
`define LEC_BIT_CLKEN 5
`define LEC_BIT_LRST 6
`define LEC_BIT_RATE 5
`define LEC_BIT_INV 4
`define LEC_BIT_DLY_HI 3
`define LEC_BIT_DLY_LO 2
`define LEC_BIT_EVSEL 3
`define LEC_BIT_CLRREC 2
`define LEC_BIT_CLRDAT 1
`define LEC_BIT_CNTEN 0
`define LEC_BIT_ACC 4
`define LEC_BIT_MASK 3
`define LEC_RST_LANE 8'h00
`define LEC_RST_CLK 8'h28
`define LEC_RST_EVT 8'h00
`define LEC_RST_ERR 8'h00
`define LEC_DLY_STEP_PS 100
`define LEC_CLK_LOSS_CNT 8'hfe
`define LEC_NUM_LANES 3
`endif

// ### pkg/lec_pkg.sv
/*
  Types of the LVDS output and event count block.
  Assumes lec_map.svh is on the include path.
*/
package lec_pkg;
  `include "lec_map.svh"
  typedef logic [7:0] lec_byte_t;
  typedef logic [1:0] lec_dly_t;
  typedef enum logic [1:0]
  {
    LEC_IDLE = 2'b00,
    LEC_RUN = 2'b01,
    LEC_HOLD = 2'b10
  } lec_out_state_t;
endpackage

// ### core/lec_sync.sv
/*
  Two-flop synchroniser for one level.
  Assumes the input is asynchronous to clk.
*/
`timescale 1ns/1ns
module lec_sync
(
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst_n,
  // Level in and out.
  input wire logic d,
  output logic q
);
  logic s1_reg;
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      s1_reg <= 1'b0;
      q <= 1'b0;
    end
    else
    begin
      s1_reg <= d;
      q <= s1_reg;
    end
  end
endmodule

// ### core/lec_top.sv
/*
  Register bank for LVDS output control, event counters and error monitor.
  Assumes a register port of address, write data, write and read strobes on core_clk,
  and event inputs and the link clock arriving from other clock domains.
*/
`timescale 1ns/1ns
`include "lec_map.svh"
module lec_top
  import lec_pkg::*;
(
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst_n,
  // Register port.
  input wire lec_pkg::lec_byte_t reg_addr,
  input wire lec_pkg::lec_byte_t reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output lec_pkg::lec_byte_t reg_rdata,
  // Link side inputs.
  input wire logic forwarded_clock,
  input wire logic lock_in,
  input wire logic code_error_in,
  input wire logic data_error_in,
  input wire logic run_start,
  // LVDS output controls.
  output logic lane2_driver_on,
  output logic lane1_driver_on,
  output logic lane0_driver_on,
  output logic clk_driver_on,
  output logic lvds_block_rst,
  output logic fwd_clock_rate_sel,
  output logic fwd_clock_polarity,
  output lec_pkg::lec_dly_t fwd_clock_delay,
  output logic lock_out
);
  import lec_pkg::*;

  // ********************************************************************
  // Input synchronisers.
  // ********************************************************************
  logic [4:0] raw_in;
  logic [4:0] syn;
  assign raw_in = {run_start, data_error_in, code_error_in, lock_in, forwarded_clock};
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi = gi + 1)
    begin : g_sync
      lec_sync u_sync
      (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .d(raw_in[gi]),
        .q(syn[gi])
      );
    end
  endgenerate

  // ********************************************************************
  // Registers.
  // ********************************************************************
  lec_byte_t lane_reg;
  lec_byte_t clk_reg;
  lec_byte_t evt_reg;
  lec_byte_t err_reg;
  logic wr_lane;
  logic wr_clk;
  logic wr_evt;
  logic wr_err;
  assign wr_lane = reg_wr && (reg_addr == `LEC_OFS_LANE);
  assign wr_clk = reg_wr && (reg_addr == `LEC_OFS_CLK);
  assign wr_evt = reg_wr && (reg_addr == `LEC_OFS_EVT);
  assign wr_err = reg_wr && (reg_addr == `LEC_OFS_ERR);

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      lane_reg <= `LEC_RST_LANE;
      clk_reg <= `LEC_RST_CLK;
      evt_reg <= `LEC_RST_EVT;
      err_reg <= `LEC_RST_ERR;
    end
    else
    begin
      if (wr_lane)
        lane_reg <= reg_wdata;
      if (wr_clk)
        clk_reg <= reg_wdata & 8'h7c;
      if (wr_evt)
        evt_reg <= reg_wdata & 8'h0f;
      if (wr_err)
        err_reg <= reg_wdata & 8'h1f;
    end
  end

  // ********************************************************************
  // Event detection.
  // ********************************************************************
  logic clk_d_reg;
  logic lock_d_reg;
  logic [7:0] clk_idle_reg;
  logic clk_lost;
  logic lock_lost;
  logic code_err;
  assign lock_lost = lock_d_reg && !syn[1];
  assign clk_lost = (clk_idle_reg == `LEC_CLK_LOSS_CNT);
  assign code_err = syn[2] && !err_reg[`LEC_BIT_MASK];

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      clk_d_reg <= 1'b0;
      lock_d_reg <= 1'b0;
      clk_idle_reg <= 8'h00;
    end
    else
    begin
      clk_d_reg <= syn[0];
      lock_d_reg <= syn[1];
      if (syn[0] != clk_d_reg)
        clk_idle_reg <= 8'h00;
      else if (clk_idle_reg != 8'hff)
        clk_idle_reg <= clk_idle_reg + 8'h01;
    end
  end

  // ********************************************************************
  // Counters.
  // ********************************************************************
  lec_byte_t rec_cnt_reg;
  lec_byte_t dat_cnt_reg;
  logic [15:0] err_cnt_reg;
  logic cnt_en;
  logic data_evt;
  assign cnt_en = evt_reg[`LEC_BIT_CNTEN];
  assign data_evt = syn[3] || code_err;

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      rec_cnt_reg <= 8'h00;
    else if (wr_evt && reg_wdata[`LEC_BIT_CLRREC])
      rec_cnt_reg <= 8'h00;
    else if (cnt_en && (clk_lost || lock_lost) && rec_cnt_reg != 8'hff)
      rec_cnt_reg <= rec_cnt_reg + 8'h01;
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      dat_cnt_reg <= 8'h00;
    else if (wr_evt && reg_wdata[`LEC_BIT_CLRDAT])
      dat_cnt_reg <= 8'h00;
    else if (cnt_en && data_evt && dat_cnt_reg != 8'hff)
      dat_cnt_reg <= dat_cnt_reg + 8'h01;
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      err_cnt_reg <= 16'h0000;
    else if (syn[4] && !err_reg[`LEC_BIT_ACC])
      err_cnt_reg <= 16'h0000;
    else if (data_evt && err_cnt_reg != 16'hffff)
      err_cnt_reg <= err_cnt_reg + 16'h0001;
  end

  // ********************************************************************
  // Read port.
  // ********************************************************************
  lec_byte_t evt_view;
  assign evt_view = evt_reg[`LEC_BIT_EVSEL] ? dat_cnt_reg : rec_cnt_reg;

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      reg_rdata <= 8'h00;
    else if (reg_rd)
    begin
      case (reg_addr)
        `LEC_OFS_LANE: reg_rdata <= lane_reg;
        `LEC_OFS_CLK: reg_rdata <= clk_reg;
        `LEC_OFS_EVT: reg_rdata <= evt_reg;
        `LEC_OFS_ERR: reg_rdata <= err_reg;
        `LEC_OFS_EVCNT: reg_rdata <= evt_view;
        `LEC_OFS_ERRLO: reg_rdata <= err_cnt_reg[7:0];
        `LEC_OFS_ERRHI: reg_rdata <= err_cnt_reg[15:8];
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  // ********************************************************************
  // Output control.
  // ********************************************************************
  lec_out_state_t st_reg;
  logic ovr;
  assign ovr = lane_reg[`LEC_BIT_OVR];

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      st_reg <= LEC_IDLE;
    else
    begin
      case (st_reg)
        LEC_IDLE: st_reg <= LEC_RUN;
        LEC_RUN: st_reg <= clk_reg[`LEC_BIT_LRST] ? LEC_HOLD : LEC_RUN;
        LEC_HOLD: st_reg <= clk_reg[`LEC_BIT_LRST] ? LEC_HOLD : LEC_RUN;
        default: st_reg <= LEC_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      lane2_driver_on <= 1'b0;
      lane1_driver_on <= 1'b0;
      lane0_driver_on <= 1'b0;
      clk_driver_on <= 1'b0;
      lvds_block_rst <= 1'b1;
      fwd_clock_rate_sel <= 1'b1;
      fwd_clock_polarity <= 1'b0;
      fwd_clock_delay <= 2'h2;
      lock_out <= 1'b0;
    end
    else
    begin
      lane2_driver_on <= ovr ? lane_reg[2] : 1'b1;
      lane1_driver_on <= ovr ? lane_reg[1] : 1'b1;
      lane0_driver_on <= ovr ? lane_reg[0] : 1'b1;
      clk_driver_on <= ovr ? lane_reg[`LEC_BIT_CLKEN] : 1'b1;
      lvds_block_rst <= (st_reg != LEC_RUN) || clk_reg[`LEC_BIT_LRST];
      fwd_clock_rate_sel <= clk_reg[`LEC_BIT_RATE];
      fwd_clock_polarity <= clk_reg[`LEC_BIT_INV];
      fwd_clock_delay <= clk_reg[`LEC_BIT_DLY_HI:`LEC_BIT_DLY_LO];
      lock_out <= syn[1] && !code_err;
    end
  end
endmodule

// ### dv/lec_props.sv
/* Port checker of lec_top.
   Assumes a bind from the bench. */
`timescale 1ns/1ns
module lec_props
  import lec_pkg::*;
(
  // Clock, reset and register port.
  input wire logic core_clk,
  input wire logic rst_n,
  input wire lec_pkg::lec_byte_t reg_addr,
  input wire lec_pkg::lec_byte_t reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  // Output controls.
  input wire logic lane2_driver_on,
  input wire logic lane1_driver_on,
  input wire logic lane0_driver_on,
  input wire logic lvds_block_rst,
  input wire logic fwd_clock_rate_sel,
  input wire logic fwd_clock_polarity,
  input wire lec_pkg::lec_dly_t fwd_clock_delay
);
  // ****
  // Checks
  // ****
  logic w27;
  logic w28;
  logic [2:0] lanes;
  assign w27 = reg_wr && reg_addr == 8'h27;
  assign w28 = reg_wr && reg_addr == 8'h28;
  assign lanes = {lane2_driver_on, lane1_driver_on, lane0_driver_on};
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  lane_on_a: assert property
    (w27 && reg_wdata[6] |-> ##2 lanes == $past(reg_wdata[2:0], 2)) else $error("lane bad");
  lane_dflt_a: assert property
    (w27 && !reg_wdata[6] |-> ##2 lanes == 3'h7) else $error("default bad");
  brst_set_a: assert property
    (w28 && reg_wdata[6] |-> ##2 lvds_block_rst) else $error("reset missing");
  brst_clr_a: assert property
    (w28 && !reg_wdata[6] ##1 !w28 [*2] |-> ##2 !lvds_block_rst) else $error("reset stuck");
  rate_sel_a: assert property
    (w28 |-> ##2 fwd_clock_rate_sel == $past(reg_wdata[5], 2)) else $error("rate bad");
  pol_flip_a: assert property
    (w28 |-> ##2 fwd_clock_polarity == $past(reg_wdata[4], 2)) else $error("polarity bad");
  delay_set_a: assert property
    (w28 |-> ##2 fwd_clock_delay == $past(reg_wdata[3:2], 2)) else $error("delay bad");
  reset_vals_a: assert property
    (disable iff (1'b0) !rst_n |=> fwd_clock_rate_sel && !fwd_clock_polarity
      && fwd_clock_delay == 2'h2 && lvds_block_rst) else $error("reset value bad");
  cover property (w28 && reg_wdata[6]);
  cover property (w27 && reg_wdata[6]);
  cover property (reg_rd && reg_addr == 8'h3d);
endmodule

// ### dv/lec_link_model.sv
/* Link clock source toward the block.
   Assumes the bench sets run. */
`timescale 1ns/1ns
module lec_link_model
(
  // Command.
  input wire logic run,
  // Link clock.
  output logic forwarded_clock
);
  // ****
  // Clock
  // ****
  // The clock stands still while run is low.
  initial forwarded_clock = 1'b0;
  always #80 if (run) forwarded_clock = !forwarded_clock;
endmodule

// ### dv/lec_top_tb.sv
/* Bench of lec_top.
   Assumes lec_props and lec_link_model. */
`timescale 1ns/1ns
module lec_top_tb;
  import lec_pkg::*;
  // ****
  // Bench
  // ****
  logic core_clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, run = 1;
  logic lock_in = 1, cerr = 0, derr = 0, start = 0;
  lec_byte_t reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic l2, l1, l0, brst, rate, pol, lock_out, fclk, cdrv;
  lec_dly_t dly;
  int fails = 0, compares = 0;
  always #2 core_clk = !core_clk;
  lec_link_model link (.run, .forwarded_clock(fclk));
  lec_top uut (.core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .forwarded_clock(fclk), .lock_in, .code_error_in(cerr), .data_error_in(derr),
    .run_start(start), .lane2_driver_on(l2), .lane1_driver_on(l1), .lane0_driver_on(l0),
    .clk_driver_on(cdrv), .lvds_block_rst(brst), .fwd_clock_rate_sel(rate),
    .fwd_clock_polarity(pol), .fwd_clock_delay(dly), .lock_out);
  task automatic chk(input lec_byte_t got, input lec_byte_t exp);
    compares++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value at %0t: got %h not %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic wr(input lec_byte_t a, input lec_byte_t d);
    tick(1);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    tick(1);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input lec_byte_t a, input lec_byte_t exp);
    tick(1);
    reg_addr = a;
    reg_rd = 1'b1;
    tick(1);
    reg_rd = 1'b0;
    chk(reg_rdata, exp);
  endtask
  task automatic outs(input lec_byte_t exp);
    tick(3);
    chk({brst, rate, pol, dly, l2, l1, l0}, exp);
  endtask
  task automatic lost_lock;
    lock_in = 1'b0;
    tick(10);
    lock_in = 1'b1;
    tick(10);
  endtask
  task automatic new_run;
    start = 1'b1;
    tick(5);
    start = 1'b0;
    tick(5);
  endtask
  // Drives a code error for six cycles and looks at the lock output.
  task automatic code_err(input lec_byte_t lk);
    cerr = 1'b1;
    tick(4);
    chk({7'h00, lock_out}, lk);
    tick(2);
    cerr = 1'b0;
    tick(6);
  endtask
  task automatic t_reset;
    outs(8'h57);
    rd(8'h27, 8'h00);
    rd(8'h28, 8'h28);
    rd(8'h2b, 8'h00);
    rd(8'h2d, 8'h00);
    wr(8'h2c, 8'hff);
    rd(8'h2c, 8'h00);
  endtask
  task automatic t_outs;
    wr(8'h27, 8'h45);
    outs(8'h55);
    chk({7'h00, cdrv}, 8'h00);
    wr(8'h27, 8'h62);
    outs(8'h52);
    chk({7'h00, cdrv}, 8'h01);
    wr(8'h27, 8'h42);
    outs(8'h52);
    chk({7'h00, cdrv}, 8'h00);
    wr(8'h27, 8'h02);
    outs(8'h57);
    chk({7'h00, cdrv}, 8'h01);
    wr(8'h28, 8'h5c);
    outs(8'hbf);
    wr(8'h28, 8'h24);
    outs(8'h4f);
    wr(8'h28, 8'hff);
    rd(8'h28, 8'h7c);
  endtask
  task automatic t_events;
    lost_lock;
    rd(8'h3d, 8'h00);
    wr(8'h2b, 8'h01);
    lost_lock;
    rd(8'h3d, 8'h01);
    run = 1'b0;
    tick(300);
    run = 1'b1;
    tick(60);
    rd(8'h3d, 8'h02);
    derr = 1'b1;
    tick(3);
    derr = 1'b0;
    tick(4);
    wr(8'h2b, 8'h09);
    rd(8'h3d, 8'h03);
    wr(8'h2b, 8'h0b);
    rd(8'h3d, 8'h00);
    wr(8'h2b, 8'h01);
    rd(8'h3d, 8'h02);
    wr(8'h2b, 8'h05);
    rd(8'h3d, 8'h00);
  endtask
  task automatic t_errors;
    new_run;
    derr = 1'b1;
    tick(5);
    derr = 1'b0;
    code_err(8'h00);
    rd(8'h3e, 8'h0b);
    wr(8'h2d, 8'h18);
    code_err(8'h01);
    new_run;
    rd(8'h3e, 8'h0b);
    rd(8'h3f, 8'h00);
    wr(8'h2d, 8'h08);
    new_run;
    rd(8'h3e, 8'h00);
  endtask
  task automatic summarize;
    if (fails == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    #100000;
    fails++;
    summarize;
  end
  initial
  begin
    tick(16);
    rst_n = 1'b1;
    tick(4);
    t_reset;
    t_outs;
    t_events;
    t_errors;
    summarize;
  end
endmodule
bind lec_top lec_props chk (.core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .lane2_driver_on, .lane1_driver_on, .lane0_driver_on, .lvds_block_rst,
  .fwd_clock_rate_sel, .fwd_clock_polarity, .fwd_clock_delay);
